// ==== core/qdl_regs.svh ====
/*
 * Timing figures, field positions and fixed values for the quad DAC loader.
 * Assumes a single system clock; counts are derived from these in the modules.
 */
`ifndef QDL_REGS_SVH
`define QDL_REGS_SVH

// System clock period
`define QDL_CLK_PERIOD_NS 20
// Least low time of a channel load strobe
`define QDL_STROBE_MIN_NS 400
// Time allowed per approximation step, trial load to comparator sample
`define QDL_SETTLE_NS 15000
// Whole twelve-step conversion
`define QDL_CONV_MAX_NS 180000

// Converter input word and field positions in a 16-bit host word
`define QDL_WORD_BITS 12
`define QDL_LEFT_LO 4
`define QDL_RIGHT_LO 0
`define QDL_IDLE_WORD 12'hfff
`define QDL_ALL_HIGH 4'hf
`define QDL_HI_NIBBLE_LO 0

// Successive approximation start values
`define QDL_SAR_FIRST 12'h800
`define QDL_SAR_TOP_BIT 4'hb

// Decoded base address of the converter
`define QDL_BASE_ADDR 8'h00

`endif

// ==== core/qdl_pkg.sv ====
/*
 * Types shared by the quad DAC loader: commands, results, pin bundle, states.
 * Assumes the user side runs on the same clock as the loader.
 */
package qdl_pkg;

    typedef enum logic [1:0] {
        CMD_WRITE_WORD,
        CMD_BYTE_FIRST,
        CMD_BYTE_SECOND,
        CMD_CONVERT
    } qdl_kind_t;

    typedef enum {
        ST_IDLE,
        ST_SETUP,
        ST_TRIAL,
        ST_STROBE,
        ST_HOLD,
        ST_SETTLE
    } qdl_state_t;

    typedef struct packed {
        logic valid;
        qdl_kind_t kind;
        logic [7:0] baseAddr;
        logic [3:0] wordAddr;
        logic leftJust;
        logic [15:0] data;
    } qdl_cmd_t;

    typedef struct packed {
        logic valid;
        logic [11:0] code;
    } qdl_result_t;

    typedef struct packed {
        logic [3:0] loadStrobeN;
        logic [11:0] converterDataInputs;
        logic dataBufEnable;
    } qdl_pins_t;

endpackage

// ==== core/qdl_sar_core.sv ====
/*
 * Successive approximation register: holds the trial word, one bit per step.
 * Assumes the caller pulses step only after the trial word has settled.
 */
`timescale 1ns/1ps
`include "qdl_regs.svh"

module qdl_sar_core import qdl_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic step,
    input wire logic keep,
    output logic [11:0] trial,
    output logic last,
    output logic done
);

    logic [11:0] trialQ;
    logic [11:0] trialD;
    logic [3:0] bitQ;
    logic doneQ;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Next trial: drop the tested bit if too high, try the next one down
    always_comb begin
        trialD = trialQ;
        if (!keep) begin
            trialD[bitQ] = 1'b0;
        end
        if (bitQ != 4'h0) begin
            trialD[bitQ - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trialQ <= 12'h000;
            bitQ <= 4'h0;
            doneQ <= 1'b0;
        end else if (start) begin
            trialQ <= `QDL_SAR_FIRST;
            bitQ <= `QDL_SAR_TOP_BIT;
            doneQ <= 1'b0;
        end else if (step) begin
            trialQ <= trialD;
            bitQ <= (bitQ == 4'h0) ? 4'h0 : bitQ - 4'h1;
            doneQ <= (bitQ == 4'h0);
        end else begin
            doneQ <= 1'b0;
        end
    end

    assign trial = trialQ;
    assign last = (bitQ == 4'h0);
    assign done = doneQ;

    ////////////////////////////////////////////////////////////////////////////
    sar_msb_first_a: assert property (start |=> trialQ == 12'h800 && bitQ == 4'hb)
        else $error("conversion did not start from the top bit");
    sar_done_pulse_a: assert property (done |=> !done)
        else $error("done pulse longer than one cycle");

endmodule

// ==== core/qdl_host_loader.sv ====
/*
 * Host glue that loads a quad 12-bit latched DAC: decodes word writes into
 * active-low channel load strobes, assembles byte pairs, and runs a software
 * style successive approximation conversion against an external comparator.
 * Assumes user commands come from logic on clk_sys; the comparator pin is
 * asynchronous. The pin bundle drives the DAC pins directly.
 */
`timescale 1ns/1ps
`include "qdl_regs.svh"

// Notes on behaviour
// - Write strobes take one word address bit per channel; conversion decodes the low two bits.
// - Each channel has its own address line so one write may load several.
// - Strobes go low only during a write or conversion whose base address matches.
// - A 16-bit word carries its 12 bits left-justified or right-justified.
// - The data buffer to the DAC is enabled only while the DAC is addressed.
// - The first byte is held in a latch and joined right-justified with the second.
// - The DAC is loaded only on the second byte write with select and write both active.
// - Unaddressed DAC data inputs sit at a defined high level.
// - Conversion runs bit by bit on one channel while the others stay outputs.
// - Each step allows 15 us before sampling; a whole conversion takes 180 us.
// - Every channel load strobe stays low for at least 400 ns.
module qdl_host_loader import qdl_pkg::*; #(
    parameter int STROBE_NS = `QDL_STROBE_MIN_NS,
    parameter int SETTLE_NS = `QDL_SETTLE_NS,
    parameter logic [7:0] BASE_ADDR = `QDL_BASE_ADDR,
    parameter logic COMP_KEEP_LEVEL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire qdl_cmd_t cmd,
    output logic cmdReady,
    output qdl_result_t result,
    input wire logic compAbovePin,
    output qdl_pins_t pins
);

    localparam int STROBE_CYC_RAW = (STROBE_NS + `QDL_CLK_PERIOD_NS - 1) / `QDL_CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
    localparam int SETTLE_CYC_RAW = SETTLE_NS / `QDL_CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < STROBE_CYC + 3) ?
        STROBE_CYC + 3 : SETTLE_CYC_RAW;
    localparam int SAR_WAIT_CYC = SETTLE_CYC - STROBE_CYC - 2;
    localparam int CONV_CYC = `QDL_CONV_MAX_NS / `QDL_CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_LOAD = CNT_W'(SAR_WAIT_CYC - 1);

    qdl_state_t stateQ;
    logic [CNT_W-1:0] cntQ;
    logic [3:0] maskQ;
    logic [11:0] wordQ;
    logic [7:0] byteHoldQ;
    logic convQ;
    logic readyQ;
    qdl_result_t resultQ;
    logic compMetaQ;
    logic compSyncQ;
    logic [3:0] strobeNQ;
    logic [11:0] dataQ;
    logic bufEnQ;

    logic accept;
    logic baseHit;
    logic [11:0] wordJust;
    logic [11:0] wordBytes;
    logic sarStart;
    logic sarStep;
    logic [11:0] sarTrial;
    logic sarLast;
    logic sarDone;
    logic driveWord;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign accept = cmd.valid && readyQ;
    assign baseHit = (cmd.baseAddr == BASE_ADDR);
    assign wordJust = cmd.leftJust ? cmd.data[`QDL_LEFT_LO +: 12]
                                   : cmd.data[`QDL_RIGHT_LO +: 12];
    assign wordBytes = {cmd.data[`QDL_HI_NIBBLE_LO +: 4], byteHoldQ};
    assign sarStart = accept && baseHit && (cmd.kind == CMD_CONVERT) && (stateQ == ST_IDLE);
    assign sarStep = (stateQ == ST_SETTLE) && (cntQ == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Comparator pin synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            compMetaQ <= 1'b0;
            compSyncQ <= 1'b0;
        end else begin
            compMetaQ <= compAbovePin;
            compSyncQ <= compMetaQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // First byte of a byte pair waits here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            byteHoldQ <= 8'h00;
        end else if (accept && baseHit && cmd.kind == CMD_BYTE_FIRST && stateQ == ST_IDLE) begin
            byteHoldQ <= cmd.data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write and conversion sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateQ <= ST_IDLE;
            cntQ <= '0;
            maskQ <= 4'h0;
            wordQ <= `QDL_IDLE_WORD;
            convQ <= 1'b0;
            readyQ <= 1'b1;
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    if (accept && baseHit) begin
                        case (cmd.kind)
                            CMD_WRITE_WORD: begin
                                wordQ <= wordJust;
                                maskQ <= cmd.wordAddr;
                                convQ <= 1'b0;
                                readyQ <= 1'b0;
                                stateQ <= ST_SETUP;
                            end
                            CMD_BYTE_SECOND: begin
                                wordQ <= wordBytes;
                                maskQ <= cmd.wordAddr;
                                convQ <= 1'b0;
                                readyQ <= 1'b0;
                                stateQ <= ST_SETUP;
                            end
                            CMD_CONVERT: begin
                                maskQ <= 4'h1 << cmd.wordAddr[1:0];
                                convQ <= 1'b1;
                                readyQ <= 1'b0;
                                stateQ <= ST_TRIAL;
                            end
                            default: begin
                                stateQ <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_SETUP: begin
                    cntQ <= STROBE_LOAD;
                    stateQ <= ST_STROBE;
                end
                ST_TRIAL: begin
                    wordQ <= sarTrial;
                    cntQ <= STROBE_LOAD;
                    stateQ <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (cntQ == '0) begin
                        stateQ <= ST_HOLD;
                    end else begin
                        cntQ <= cntQ - 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (convQ) begin
                        cntQ <= WAIT_LOAD;
                        stateQ <= ST_SETTLE;
                    end else begin
                        readyQ <= 1'b1;
                        stateQ <= ST_IDLE;
                    end
                end
                ST_SETTLE: begin
                    if (cntQ != '0) begin
                        cntQ <= cntQ - 1'b1;
                    end else if (sarLast) begin
                        convQ <= 1'b0;
                        readyQ <= 1'b1;
                        stateQ <= ST_IDLE;
                    end else begin
                        stateQ <= ST_TRIAL;
                    end
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    qdl_sar_core u_sar (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(sarStart),
        .step(sarStep),
        .keep(compSyncQ == COMP_KEEP_LEVEL),
        .trial(sarTrial),
        .last(sarLast),
        .done(sarDone)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resultQ <= '0;
        end else begin
            resultQ.valid <= sarDone;
            if (sarDone) begin
                resultQ.code <= sarTrial;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DAC pins, one cycle behind the sequencer
    assign driveWord = (stateQ == ST_SETUP) || (stateQ == ST_STROBE) || (stateQ == ST_HOLD);

    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_strobe
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    strobeNQ[ch] <= 1'b1;
                end else begin
                    strobeNQ[ch] <= !((stateQ == ST_STROBE) && maskQ[ch]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dataQ <= `QDL_IDLE_WORD;
            bufEnQ <= 1'b0;
        end else begin
            dataQ <= driveWord ? wordQ : `QDL_IDLE_WORD;
            bufEnQ <= driveWord;
        end
    end

    assign pins.loadStrobeN = strobeNQ;
    assign pins.converterDataInputs = dataQ;
    assign pins.dataBufEnable = bufEnQ;
    assign cmdReady = readyQ;
    assign result = resultQ;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] lowRunQ;
    logic [15:0] stepGapQ;
    logic [15:0] convRunQ;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lowRunQ <= 8'h00;
            stepGapQ <= 16'h0000;
            convRunQ <= 16'h0000;
        end else begin
            lowRunQ <= (strobeNQ == `QDL_ALL_HIGH) ? 8'h00 :
                       (lowRunQ == 8'hff) ? lowRunQ : lowRunQ + 8'h01;
            stepGapQ <= (sarStart || sarStep) ? 16'h0000 : stepGapQ + 16'h0001;
            convRunQ <= sarStart ? 16'h0000 : convRunQ + 16'h0001;
        end
    end

    idle_strobes_high_a: assert property (stateQ == ST_IDLE |=> strobeNQ == 4'hf)
        else $error("load strobe low while idle");
    strobe_width_a: assert property (
        (strobeNQ == 4'hf && $past(strobeNQ) != 4'hf) |-> lowRunQ >= STROBE_CYC)
        else $error("load strobe pulse too short");
    data_hold_a: assert property (
        (strobeNQ != 4'hf && $past(strobeNQ) != 4'hf) |-> $stable(dataQ))
        else $error("data changed while a strobe was low");
    rise_hold_a: assert property (
        (strobeNQ != 4'hf) ##1 (strobeNQ == 4'hf) |-> dataQ == $past(dataQ) && bufEnQ)
        else $error("data not held through strobe release");
    idle_data_high_a: assert property (!bufEnQ |-> dataQ == 12'hfff)
        else $error("unaddressed data inputs not high");
    buffer_gate_a: assert property (strobeNQ != 4'hf |-> bufEnQ)
        else $error("strobe low without buffer enabled");
    word_justify_a: assert property (
        (accept && baseHit && cmd.kind == CMD_WRITE_WORD && stateQ == ST_IDLE)
        |-> ##3 (dataQ == $past(wordJust, 3) && strobeNQ == ~$past(cmd.wordAddr, 3)))
        else $error("word write not loaded as decoded");
    byte_pair_a: assert property (
        (accept && baseHit && cmd.kind == CMD_BYTE_SECOND && stateQ == ST_IDLE)
        |-> ##3 (dataQ == {$past(cmd.data[3:0], 3), $past(byteHoldQ, 3)}))
        else $error("byte pair assembled wrongly");
    first_byte_quiet_a: assert property (
        (accept && cmd.kind == CMD_BYTE_FIRST) |=> readyQ ##1 strobeNQ == 4'hf)
        else $error("first byte loaded the converter");
    foreign_base_a: assert property (
        (accept && !baseHit) |=> stateQ == ST_IDLE ##1 strobeNQ == 4'hf)
        else $error("strobe for a foreign base address");
    one_channel_conv_a: assert property (
        (convQ && strobeNQ != 4'hf) |-> $onehot(~strobeNQ))
        else $error("conversion touched more than one channel");
    step_spacing_a: assert property (sarStep |-> stepGapQ == SETTLE_CYC - 1)
        else $error("approximation step spacing wrong");
    conv_length_a: assert property (sarDone |-> convRunQ <= CONV_CYC)
        else $error("conversion exceeded its time budget");

endmodule

// ==== verif/qdl_dac_model.sv ====
/*
 * Behavioural model of the quad latched DAC and its comparator.
 * Assumes the loader drives the pin bundle; the comparator is ideal and instant.
 */
`timescale 1ns/1ps

module qdl_dac_model import qdl_pkg::*; (
    input wire qdl_pins_t pins,
    input wire logic [11:0] analogIn,
    input wire logic [1:0] compChan,
    output logic compAbovePin,
    output logic [3:0][11:0] dacOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Four channel latches, any mix may be open at once
    for (genvar i = 0; i < 4; i++) begin : g_chan
        always_latch begin
            if (!pins.loadStrobeN[i]) begin
                dacOut[i] = pins.converterDataInputs;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparator: high while input is at or above the selected output
    assign compAbovePin = (analogIn >= dacOut[compChan]);

endmodule

// ==== verif/quad_dac_bus_loader_tb.sv ====
/*
 * Self-checking bench for the quad DAC host loader.
 * Assumes a DAC model on the pin bundle and shortened strobe and settle times.
 */
`timescale 1ns/1ps

module quad_dac_bus_loader_tb import qdl_pkg::*; ;

    localparam int STROBE_CYC = 3;
    localparam int CONV_CYC = 12 * 10 + 2;

    typedef struct {
        logic [3:0] addr;
        logic left;
        logic [15:0] data;
        logic [3:0][11:0] exp;
    } qdl_row_t;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    qdl_cmd_t cmd = '0;
    logic cmdReady;
    qdl_result_t result;
    logic compAbovePin;
    qdl_pins_t pins;
    logic [11:0] analogIn = 12'h000;
    logic [1:0] compChan = 2'h0;
    logic [3:0][11:0] dacOut;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int falls = 0;
    int lowCnt [4];
    logic rstSeen = 1'b0;
    qdl_row_t rows [6];

    qdl_host_loader #(.STROBE_NS(60), .SETTLE_NS(200)) u_qdl_host_loader (
        .clk_sys(clk_sys),
        .rst(rst),
        .cmd(cmd),
        .cmdReady(cmdReady),
        .result(result),
        .compAbovePin(compAbovePin),
        .pins(pins)
    );

    qdl_dac_model u_qdl_dac_model (
        .pins(pins),
        .analogIn(analogIn),
        .compChan(compChan),
        .compAbovePin(compAbovePin),
        .dacOut(dacOut)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            errors++;
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic send(input qdl_kind_t k, input logic [7:0] b, input logic [3:0] a,
                        input logic l, input logic [15:0] d);
        int n;
        @(posedge clk_sys);
        cmd <= '{valid: 1'b1, kind: k, baseAddr: b, wordAddr: a, leftJust: l, data: d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmdReady !== 1'b1 && n < 100);
        cmd.valid <= 1'b0;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        repeat (2) @(posedge clk_sys);
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (cmdReady !== 1'b1 && n < 100);
        check("ready returned", 12'(n < 100), 12'h1);
    endtask

    task automatic check_chans(input logic [3:0][11:0] exp);
        for (int i = 0; i < 4; i++) begin
            check($sformatf("channel %0d", i + 1), dacOut[i], exp[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Pin monitors: strobe width, strobe count, quiet during reset
    // Cycle ceiling, several times the expected run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles > 2000) begin
            errors++;
            give_verdict();
        end
    end

    always @(posedge clk_sys) begin
        rstSeen <= rst;
        if (rstSeen) begin
            check("strobes in reset", 12'(pins.loadStrobeN), 12'hf);
        end
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                lowCnt[i] = 0;
            end else if (pins.loadStrobeN[i] === 1'b0) begin
                if (lowCnt[i] == 0) begin
                    falls++;
                end
                lowCnt[i]++;
            end else if (lowCnt[i] > 0) begin
                check("strobe width", 12'(lowCnt[i]), 12'(STROBE_CYC));
                lowCnt[i] = 0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int f0;
        int n;
        rows[0] = '{4'hf, 1'b0, 16'h0555, {12'h555, 12'h555, 12'h555, 12'h555}};
        rows[1] = '{4'h1, 1'b0, 16'hfabc, {12'h555, 12'h555, 12'h555, 12'habc}};
        rows[2] = '{4'h2, 1'b1, 16'h1234, {12'h555, 12'h555, 12'h123, 12'habc}};
        rows[3] = '{4'hc, 1'b1, 16'hfff0, {12'hfff, 12'hfff, 12'h123, 12'habc}};
        rows[4] = '{4'h8, 1'b0, 16'h0000, {12'h000, 12'hfff, 12'h123, 12'habc}};
        rows[5] = '{4'h5, 1'b1, 16'h8007, {12'h000, 12'h800, 12'h123, 12'h800}};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("ready after reset", 12'(cmdReady), 12'h1);
        check("result after reset", 12'(result.valid), 12'h0);
        check("data idle", pins.converterDataInputs, 12'hfff);
        check("buffer idle", 12'(pins.dataBufEnable), 12'h0);
        foreach (rows[r]) begin
            send(CMD_WRITE_WORD, 8'h00, rows[r].addr, rows[r].left, rows[r].data);
            wait_ready();
            check_chans(rows[r].exp);
        end
        repeat (2) @(posedge clk_sys);
        #1;
        check("data idle after write", pins.converterDataInputs, 12'hfff);
        check("buffer off after write", 12'(pins.dataBufEnable), 12'h0);
        f0 = falls;
        send(CMD_WRITE_WORD, 8'h01, 4'hf, 1'b0, 16'h0000);
        repeat (8) @(posedge clk_sys);
        #1;
        check("foreign base strobes", 12'(falls - f0), 12'h0);
        check_chans(rows[5].exp);
        send(CMD_BYTE_FIRST, 8'h00, 4'h4, 1'b0, 16'h0034);
        repeat (8) @(posedge clk_sys);
        #1;
        check("first byte strobes", 12'(falls - f0), 12'h0);
        send(CMD_BYTE_SECOND, 8'h00, 4'h4, 1'b0, 16'h0002);
        wait_ready();
        check_chans({12'h000, 12'h234, 12'h123, 12'h800});
        compChan = 2'h1;
        analogIn = 12'h9a5;
        send(CMD_CONVERT, 8'h00, 4'h1, 1'b0, 16'h0000);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (result.valid !== 1'b1 && n < 2000);
        check("conversion in time", 12'(n <= CONV_CYC), 12'h1);
        check("conversion code", result.code, 12'h9a5);
        check("channel 1 kept", dacOut[0], 12'h800);
        check("channel 3 kept", dacOut[2], 12'h234);
        check("channel 4 kept", dacOut[3], 12'h000);
        wait_ready();
        send(CMD_WRITE_WORD, 8'h00, 4'hf, 1'b0, 16'h0111);
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("strobes after reset", 12'(pins.loadStrobeN), 12'hf);
        check("channel 1 after abort", dacOut[0], 12'h800);
        give_verdict();
    end

endmodule
